/* design/boot_mode_sequencer.sv */
// boot mode sequencer with its axi4-lite register slave
// Notes on behaviour
// - every boot starts fetching vectors at 0xFFFF00
// - select 0000 disables the boot rom
// - any other select enables the boot rom
// - direct mode routes rom space externally, no routine
// - select 0001 branches to external 0x080000
// - select 0010 ends in idle, not application
// - select 0101 branches to internal 0x010000
// - other selects branch to internal 0x024000
// - idle sequence: watchdog, shared, idle, host-only, halt
// - idle is left only by a reset
// - warm boot reruns without memory reload
// - rom enabled vectors lead to 0xFF8000
// - poll ram host-only flag until shared, forever
// - stack pointers 0xA0, 0xC0, dual stack fast return
// - set irq mask, clear sign extension, clear legacy
// - dispatch on select only after initialisation
// - core reads config at io address 0x000F only
// - select in bits 3 to 0, rest zero
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
module boot_mode_sequencer
  import boot_seq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ram_host_only_flag,
  input wire logic [15:0] core_io_addr,
  input wire logic core_io_rd,
  output logic [15:0] core_io_rdata_r,
  output logic [23:0] pc_r,
  output logic run_r,
  output logic rom_en_r,
  output logic ext_map_r,
  output logic [23:0] data_stack_ptr_r,
  output logic [23:0] system_stack_ptr_r,
  output logic dual_stack_fast_r,
  output logic global_irq_mask_r,
  output logic sign_ext_mode_bit_r,
  output logic legacy_compat_bit_r,
  output logic wdog_disable_r,
  output logic ram_host_only_wr_r,
  output logic periph_host_only_wr_r,
  output logic idle_all_domains_r,
  output logic core_idle_r
);
  seq_state_t st_r;
  logic hold_r;
  logic [3:0] boot_select_bits_r;
  logic aw_got_r;
  logic w_got_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_fire;
  logic capture;
  logic [3:0] dec_mode;
  logic dec_rom_en;
  logic dec_idle;
  logic [23:0] dec_target;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  assign wr_fire = ce && aw_got_r && w_got_r && !s_axi_bvalid;
  assign capture = (st_r == S_HOLD) && !hold_r;

  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    logic [31:0] v;
    v = '0;
    unique case (a)
      REG_BOOT_CFG: v[SEL_W-1:0] = boot_select_bits_r;
      REG_CTRL: v[CTRL_HOLD_BIT] = hold_r;
      REG_STATUS: v = {21'h0, core_idle_r, run_r, rom_en_r, dec_mode, st_r};
      default: v = '0;
    endcase
    return v;
  endfunction

  function automatic logic known(input logic [7:0] a);
    return (a == REG_BOOT_CFG) || (a == REG_CTRL) || (a == REG_STATUS);
  endfunction

  // write channel: address and data taken in either order, one response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= known(aw_addr_r) ? RESP_OKAY : RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // register writes; the select is only taken while the core is held, which also keeps it stable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_r <= CTRL_HOLD_RST;
      boot_select_bits_r <= BOOT_CFG_RST;
    end else if (wr_fire && w_strb_r[0]) begin
      if (aw_addr_r == REG_CTRL) begin
        hold_r <= w_data_r[CTRL_HOLD_BIT];
      end
      if (aw_addr_r == REG_BOOT_CFG && hold_r) begin
        boot_select_bits_r <= w_data_r[SEL_W-1:0];
      end
    end
  end

  // read channel: data one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux(s_axi_araddr);
        s_axi_rresp <= known(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // core side sees the config read-only at one io address, zero elsewhere
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_io_rdata_r <= 16'h0000;
    end else if (ce && core_io_rd) begin
      core_io_rdata_r <= (core_io_addr == CORE_IO_CFG) ? {12'h000, boot_select_bits_r} : 16'h0000;
    end
  end

  boot_decode u_decode (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .capture(capture),
    .sel(boot_select_bits_r),
    .mode_q(dec_mode),
    .rom_en(dec_rom_en),
    .is_idle(dec_idle),
    .target(dec_target)
  );

  // boot sequence; the hold bit acts as the subsystem reset, so a warm boot just reruns it
  always_ff @(posedge aclk) begin
    if (!aresetn || (ce && hold_r)) begin
      st_r <= S_HOLD;
      pc_r <= VEC_ADDR;
      run_r <= 1'b0;
      rom_en_r <= 1'b0;
      ext_map_r <= 1'b0;
      data_stack_ptr_r <= 24'h000000;
      system_stack_ptr_r <= 24'h000000;
      dual_stack_fast_r <= 1'b0;
      global_irq_mask_r <= IRQ_MASK_RST;
      sign_ext_mode_bit_r <= SXM_RST;
      legacy_compat_bit_r <= COMPAT_RST;
      wdog_disable_r <= 1'b0;
      ram_host_only_wr_r <= HOM_RST;
      periph_host_only_wr_r <= HOM_RST;
      idle_all_domains_r <= 1'b0;
      core_idle_r <= 1'b0;
    end else if (ce) begin
      unique case (st_r)
        S_HOLD: begin
          pc_r <= VEC_ADDR;
          st_r <= S_VEC;
        end
        S_VEC: begin
          rom_en_r <= dec_rom_en;
          ext_map_r <= !dec_rom_en;
          if (!dec_rom_en) begin
            run_r <= 1'b1;
            st_r <= S_DIRECT;
          end else begin
            pc_r <= ROM_ENTRY;
            st_r <= S_ROM;
          end
        end
        S_DIRECT: st_r <= S_DIRECT;
        S_ROM: st_r <= S_POLL;
        S_POLL: begin
          // no mode change is requested here: waiting on the host is intended, even forever
          if (!ram_host_only_flag) begin
            st_r <= S_INIT;
          end
        end
        S_INIT: begin
          data_stack_ptr_r <= SP_INIT;
          system_stack_ptr_r <= SSP_INIT;
          dual_stack_fast_r <= 1'b1;
          global_irq_mask_r <= 1'b1;
          sign_ext_mode_bit_r <= 1'b0;
          legacy_compat_bit_r <= 1'b0;
          st_r <= S_DISP;
        end
        S_DISP: begin
          if (dec_idle) begin
            st_r <= S_WDOG;
          end else begin
            pc_r <= dec_target;
            run_r <= 1'b1;
            st_r <= S_RUN;
          end
        end
        S_RUN: st_r <= S_RUN;
        S_WDOG: begin
          wdog_disable_r <= 1'b1;
          st_r <= S_SAM;
        end
        S_SAM: begin
          ram_host_only_wr_r <= 1'b0;
          periph_host_only_wr_r <= 1'b0;
          st_r <= S_ICR;
        end
        S_ICR: begin
          idle_all_domains_r <= 1'b1;
          st_r <= S_HOM;
        end
        S_HOM: begin
          ram_host_only_wr_r <= 1'b1;
          periph_host_only_wr_r <= 1'b1;
          st_r <= S_IDLE;
        end
        S_IDLE: begin
          core_idle_r <= 1'b1;
        end
        default: st_r <= S_HOLD;
      endcase
    end
  end

  vec_first_a: assert property ((st_r == S_VEC) |-> pc_r == VEC_ADDR)
    else $error("boot did not start at vector table");
  direct_ext_a: assert property ((st_r == S_DIRECT) |-> !rom_en_r && ext_map_r && pc_r == VEC_ADDR)
    else $error("direct mode left rom mapped");
  rom_entry_a: assert property ((st_r == S_ROM) |-> rom_en_r && pc_r == ROM_ENTRY)
    else $error("rom routine entry wrong");
  poll_wait_a: assert property ((st_r == S_POLL && ram_host_only_flag && !hold_r) |=>
    st_r == S_POLL && ram_host_only_wr_r)
    else $error("left polling while ram host-only");
  init_vals_a: assert property ((st_r == S_DISP) |-> data_stack_ptr_r == SP_INIT &&
    system_stack_ptr_r == SSP_INIT && dual_stack_fast_r && global_irq_mask_r &&
    !sign_ext_mode_bit_r && !legacy_compat_bit_r)
    else $error("initialisation values wrong at dispatch");
  branch_target_a: assert property ((st_r == S_DISP && ce && !hold_r && !dec_idle) |=>
    run_r && pc_r == $past(dec_target) && st_r == S_RUN)
    else $error("dispatch branch wrong");
  idle_order_a: assert property ((st_r == S_WDOG && ce && !hold_r) |=>
    wdog_disable_r && ram_host_only_wr_r && !idle_all_domains_r && st_r == S_SAM)
    else $error("idle sequence out of order");
  idle_hom_a: assert property ((st_r == S_HOM && ce && !hold_r) |=>
    idle_all_domains_r && ram_host_only_wr_r && periph_host_only_wr_r && !core_idle_r)
    else $error("host-only not restored before halt");
  idle_stays_a: assert property ((st_r == S_IDLE && !hold_r) |=> st_r == S_IDLE)
    else $error("idle left without reset");
  io_read_a: assert property ((ce && core_io_rd && core_io_addr == CORE_IO_CFG) |=>
    core_io_rdata_r == {12'h000, $past(boot_select_bits_r)})
    else $error("core io read of config wrong");
  sel_locked_a: assert property ((!hold_r) |=> $stable(boot_select_bits_r))
    else $error("select changed while core released");
endmodule

/* pkg/boot_seq_pkg.sv */
// constants, register map and state type of the boot mode sequencer
package boot_seq_pkg;
  localparam int SEL_W = 4;
  localparam logic [3:0] MODE_DIRECT = 4'h0;
  localparam logic [3:0] MODE_EXT = 4'h1;
  localparam logic [3:0] MODE_IDLE = 4'h2;
  localparam logic [3:0] MODE_INT_A = 4'h5;
  localparam logic [23:0] VEC_ADDR = 24'hFFFF00;
  localparam logic [23:0] ROM_ENTRY = 24'hFF8000;
  localparam logic [23:0] EXT_ENTRY = 24'h080000;
  localparam logic [23:0] INT_ENTRY_A = 24'h010000;
  localparam logic [23:0] INT_ENTRY_B = 24'h024000;
  localparam logic [23:0] SP_INIT = 24'h0000A0;
  localparam logic [23:0] SSP_INIT = 24'h0000C0;
  localparam logic [15:0] CORE_IO_CFG = 16'h000F;
  localparam logic [7:0] REG_BOOT_CFG = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam int CTRL_HOLD_BIT = 0;
  localparam logic CTRL_HOLD_RST = 1'b1;
  localparam logic [3:0] BOOT_CFG_RST = 4'h0;
  localparam logic IRQ_MASK_RST = 1'b1;
  localparam logic SXM_RST = 1'b1;
  localparam logic COMPAT_RST = 1'b1;
  localparam logic HOM_RST = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [3:0] {
    S_HOLD = 4'h0,
    S_VEC = 4'h1,
    S_DIRECT = 4'h2,
    S_ROM = 4'h3,
    S_POLL = 4'h4,
    S_INIT = 4'h5,
    S_DISP = 4'h6,
    S_RUN = 4'h7,
    S_WDOG = 4'h8,
    S_SAM = 4'h9,
    S_ICR = 4'hA,
    S_HOM = 4'hB,
    S_IDLE = 4'hC
  } seq_state_t;
endpackage

/* design/boot_decode.sv */
// boot select decoder, captured once at release from reset
module boot_decode
  import boot_seq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic capture,
  input wire logic [3:0] sel,
  output logic [3:0] mode_q,
  output logic rom_en,
  output logic is_idle,
  output logic [23:0] target
);
  // everything below is frozen until the next capture, so a late host write cannot re-steer a running boot
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= BOOT_CFG_RST;
      rom_en <= 1'b0;
      is_idle <= 1'b0;
      target <= INT_ENTRY_B;
    end else if (ce && capture) begin
      mode_q <= sel;
      rom_en <= (sel != MODE_DIRECT);
      is_idle <= (sel == MODE_IDLE);
      unique case (sel)
        MODE_EXT: target <= EXT_ENTRY;
        MODE_INT_A: target <= INT_ENTRY_A;
        default: target <= INT_ENTRY_B;
      endcase
    end
  end

  sel_stable_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !capture |=> $stable(mode_q) && $stable(rom_en) && $stable(target))
    else $error("boot select changed without capture");
  rom_decode_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && capture) |=> rom_en == ($past(sel) != MODE_DIRECT))
    else $error("boot rom enable decode wrong");
endmodule

/* test/host_ram_model.sv */
// far-side model of the host: holds port ram host-only while loading, then shares it
module host_ram_model (
  input wire logic aclk,
  input wire logic held,
  input wire logic [7:0] load_cycles,
  output logic ram_host_only_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_r = 8'h00;
  // a slow host keeps the ram for load_cycles after release, so the poll is really exercised
  always @(posedge aclk) begin
    if (held) begin
      cnt_r <= 8'h00;
      ram_host_only_flag <= 1'b1;
    end else if (cnt_r < load_cycles) begin
      cnt_r <= cnt_r + 8'h01;
    end else begin
      ram_host_only_flag <= 1'b0;
    end
  end
endmodule

/* test/boot_mode_sequencer_tb_top.sv */
// self-checking bench for the boot mode sequencer
module boot_mode_sequencer_tb_top;
  import boot_seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, held = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, load_cycles = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ram_host_only_flag;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [15:0] core_io_rdata_r;
  logic [15:0] core_io_addr = CORE_IO_CFG;
  logic [23:0] pc_r, data_stack_ptr_r, system_stack_ptr_r;
  logic run_r, rom_en_r, ext_map_r, dual_stack_fast_r, global_irq_mask_r, sign_ext_mode_bit_r;
  logic legacy_compat_bit_r, wdog_disable_r, ram_host_only_wr_r, periph_host_only_wr_r;
  logic idle_all_domains_r, core_idle_r;
  logic [3:0] modes[6];
  logic [33:0] exp_q[$];
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;

  boot_mode_sequencer dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .ram_host_only_flag(ram_host_only_flag), .core_io_addr(core_io_addr), .core_io_rd(1'b1),
    .core_io_rdata_r(core_io_rdata_r), .pc_r(pc_r), .run_r(run_r), .rom_en_r(rom_en_r), .ext_map_r(ext_map_r),
    .data_stack_ptr_r(data_stack_ptr_r), .system_stack_ptr_r(system_stack_ptr_r),
    .dual_stack_fast_r(dual_stack_fast_r), .global_irq_mask_r(global_irq_mask_r),
    .sign_ext_mode_bit_r(sign_ext_mode_bit_r), .legacy_compat_bit_r(legacy_compat_bit_r),
    .wdog_disable_r(wdog_disable_r), .ram_host_only_wr_r(ram_host_only_wr_r),
    .periph_host_only_wr_r(periph_host_only_wr_r), .idle_all_domains_r(idle_all_domains_r),
    .core_idle_r(core_idle_r));

  host_ram_model host (.aclk(aclk), .held(held), .load_cycles(load_cycles), .ram_host_only_flag(ram_host_only_flag));

  initial begin
    forever #10 aclk = ~aclk;
  end

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (miscompares == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // a hang anywhere ends here; the full run needs well under a thousand cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  // responses arrive in issue order since only one transfer is ever outstanding
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, exp_q.pop_front());
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    exp_q.push_back({er, 32'h0});
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    exp_q.push_back(e);
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  task automatic boot(input logic [3:0] sel, input logic [7:0] dly, input bit reload);
    int t;
    int step;
    logic [23:0] tgt;
    seq_state_t fin;
    t = 0;
    step = 0;
    tgt = (sel == MODE_EXT) ? EXT_ENTRY : (sel == MODE_INT_A) ? INT_ENTRY_A : INT_ENTRY_B;
    fin = (sel == MODE_DIRECT) ? S_DIRECT : (sel == MODE_IDLE) ? S_IDLE : S_RUN;
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    held <= 1'b1;
    load_cycles <= dly;
    if (reload) wr(REG_BOOT_CFG, {28'($urandom), sel}, RESP_OKAY);
    rd(REG_BOOT_CFG, {30'h0, sel});
    chk(core_io_rdata_r, {12'h000, sel});
    // a frozen clock enable must hold the io data even though the address moved away
    ce <= 1'b0;
    core_io_addr <= 16'($urandom_range(16, 65535));
    repeat (2) @(posedge aclk);
    chk(core_io_rdata_r, {12'h000, sel});
    ce <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(core_io_rdata_r, 16'h0000);
    core_io_addr <= CORE_IO_CFG;
    wr(REG_CTRL, 32'h0, RESP_OKAY);
    held <= 1'b0;
    while (!run_r && !core_idle_r) begin
      @(posedge aclk);
      t++;
      if (wdog_disable_r && step == 0) step = 1;
      if (!ram_host_only_wr_r && !periph_host_only_wr_r && step == 1) step = 2;
      if (idle_all_domains_r && step == 2) step = 3;
      if (ram_host_only_wr_r && periph_host_only_wr_r && step == 3) step = 4;
      if (t == 3 && sel != MODE_DIRECT) chk(pc_r, ROM_ENTRY);
    end
    chk(rom_en_r, sel != MODE_DIRECT);
    chk(ext_map_r, sel == MODE_DIRECT);
    if (sel == MODE_DIRECT) begin
      chk(pc_r, VEC_ADDR);
      chk(data_stack_ptr_r, 24'h000000);
    end else begin
      chk(ram_host_only_flag, 1'b0);
      chk(data_stack_ptr_r, SP_INIT);
      chk(system_stack_ptr_r, SSP_INIT);
      chk(dual_stack_fast_r, 1'b1);
      chk({global_irq_mask_r, sign_ext_mode_bit_r, legacy_compat_bit_r}, 3'b100);
    end
    if (sel == MODE_IDLE) begin
      chk({step == 4, run_r}, 2'b10);
      repeat (30) @(posedge aclk);
      chk(core_idle_r, 1'b1);
    end else if (sel != MODE_DIRECT) begin
      chk(pc_r, tgt);
    end
    // a select change while released must be ignored
    wr(REG_BOOT_CFG, {28'h0, ~sel}, RESP_OKAY);
    rd(REG_BOOT_CFG, {30'h0, sel});
    chk(rom_en_r, sel != MODE_DIRECT);
    // status: idle, run, rom enable, captured select, final state
    rd(REG_STATUS, {23'h0, sel == MODE_IDLE, sel != MODE_IDLE, sel != MODE_DIRECT, sel, fin});
  endtask

  initial begin
    void'($urandom(79129));
    // selects outside the named modes are programmed too: 0xF and a random one from 6 to 14
    modes = '{MODE_DIRECT, MODE_EXT, MODE_IDLE, MODE_INT_A, 4'hF, 4'h6};
    modes[5] = 4'($urandom_range(6, 14));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(REG_BOOT_CFG, 34'h0);
    rd(8'h0C, {RESP_DECERR, 32'h0});
    wr(8'h0C, 32'h0, RESP_DECERR);
    foreach (modes[i]) boot(modes[i], 8'($urandom_range(0, 20)), 1'b1);
    boot(MODE_INT_A, 8'd2, 1'b1);
    boot(MODE_INT_A, 8'd40, 1'b0);
    boot(MODE_IDLE, 8'd3, 1'b1);
    aresetn <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(core_idle_r, 1'b0);
    tally_and_finish();
  end
endmodule
